// >>> common/aimavg_cfg.svh
/*
 Constants for the two-channel analog moving-average block: register indices,
 field positions, reset values and timing. Assumes a 100 MHz system clock.
*/
`ifndef AIMAVG_CFG_SVH
`define AIMAVG_CFG_SVH

// Clock and sampling
`define CLK_MHZ 100
`define SAMPLE_PERIOD_US 2000

// Window lengths in samples
`define WIN_2MS 13'h0001
`define WIN_100MS 13'h0032
`define WIN_1000MS 13'h01f4
`define WIN_10000MS 13'h1388

// Register indices; byte address is four times the index
`define REG_CH0_IDX 12'h320
`define REG_CH1_IDX 12'h322
`define REG_CFG_IDX 12'h324
`define REG_STAT_IDX 12'h325

// Configuration fields
`define CFG_FILT_LSB 0
`define CFG_RANGE_LSB 8
`define CFG_FILT_RST 2'h2
`define CFG_RANGE_RST 2'h0

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> common/aimavg_pkg.sv
/*
 Types of the analog moving-average block. Assumes aimavg_cfg.svh for numbers.
*/
package aimavg_pkg;
   typedef enum logic [1:0] {
      FILT_2MS = 2'h0,
      FILT_100MS = 2'h1,
      FILT_1000MS = 2'h2,
      FILT_10000MS = 2'h3
   } filt_t;

   // One bit per channel, set for the current range
   typedef struct packed {
      logic [1:0] range_current;
      filt_t filt;
   } cfg_t;

   typedef enum logic [1:0] {
      DIV_IDLE = 2'b01,
      DIV_RUN = 2'b10
   } div_state_t;
endpackage : aimavg_pkg

// >>> src/mean_divider.sv
/*
 Sequential restoring divider: running sum over sample count.
 Assumes divisor is non-zero and the quotient fits in 16 bits.
*/
`timescale 1ns/1ps
`default_nettype none
module mean_divider
   import aimavg_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic arst_n,
   // Request
   input wire logic start,
   input wire logic [31:0] dividend,
   input wire logic [12:0] divisor,
   // Answer
   output logic done,
   output logic [15:0] quotient
);
   div_state_t state;
   logic [31:0] num;
   logic [13:0] rem;
   logic [5:0] step;
   logic [12:0] dvs;
   logic [13:0] trial;

   assign trial = {rem[12:0], num[31]};

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= DIV_IDLE;
         num <= 32'h0;
         rem <= 14'h0;
         step <= 6'h0;
         dvs <= 13'h0;
         done <= 1'b0;
         quotient <= 16'h0;
      end else begin
         done <= 1'b0;
         case (state)
            DIV_IDLE: begin
               if (start) begin
                  num <= dividend;
                  dvs <= divisor;
                  rem <= 14'h0;
                  step <= 6'h0;
                  state <= DIV_RUN;
               end
            end
            DIV_RUN: begin
               if (trial >= {1'b0, dvs}) begin
                  rem <= trial - {1'b0, dvs};
                  num <= {num[30:0], 1'b1};
               end else begin
                  rem <= trial;
                  num <= {num[30:0], 1'b0};
               end
               step <= step + 6'h1;
               if (step == 6'h1f) begin
                  quotient <= (trial >= {1'b0, dvs}) ? {num[14:0], 1'b1} : {num[14:0], 1'b0};
                  done <= 1'b1;
                  state <= DIV_IDLE;
               end
            end
            default: state <= DIV_IDLE;
         endcase
      end
   end
endmodule : mean_divider
`default_nettype wire

// >>> src/avg_window.sv
/*
 Sample history and running sum of one channel over a sliding window.
 Assumes win_len stays between 1 and 5000 and restart follows any change of it.
*/
`timescale 1ns/1ps
`default_nettype none
module avg_window
   import aimavg_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic arst_n,
   // Control
   input wire logic restart,
   input wire logic [12:0] win_len,
   // Sample in
   input wire logic sample_en,
   input wire logic [15:0] sample,
   // Running state
   output logic [31:0] sum,
   output logic [12:0] count,
   output logic upd
);
   logic [15:0] hist [0:4999];
   logic [12:0] wp;
   logic full;

   assign full = (count == win_len);

   // History is plain storage, no reset needed
   always_ff @(posedge clk) begin
      if (sample_en && !restart) begin
         hist[wp] <= sample;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sum <= 32'h0;
         count <= 13'h0;
         wp <= 13'h0;
         upd <= 1'b0;
      end else begin
         upd <= sample_en && !restart;
         if (restart) begin
            sum <= 32'h0;
            count <= 13'h0;
            wp <= 13'h0;
         end else if (sample_en) begin
            if (full) begin
               sum <= sum - {16'h0, hist[wp]} + {16'h0, sample};
            end else begin
               sum <= sum + {16'h0, sample};
               count <= count + 13'h1;
            end
            wp <= (wp == win_len - 13'h1) ? 13'h0 : wp + 13'h1;
         end
      end
   end

   a_sum_slide: assert property (@(posedge clk) disable iff (!arst_n)
      sample_en && !restart && full |=> sum == $past(sum) - {16'h0, $past(hist[wp])} + {16'h0, $past(sample)})
      else $error("window sum did not slide");
   a_fill_bound: assert property (@(posedge clk) disable iff (!arst_n)
      !restart && count < win_len && sample_en |=> count == $past(count) + 13'h1)
      else $error("fill count did not grow");
endmodule : avg_window
`default_nettype wire

// >>> src/analog_input_moving_average.sv
/*
 Two-channel analog input moving-average filter with an AXI4-Lite register slave.
 Assumes the converter front end holds CONV_DATA valid at every sampling tick,
 and that range selection is applied by the front end from RANGE_CURRENT.
*/
// How it works
// - Every 2 ms one converted sample per channel is taken into that channel's window.
// - In steady state each new sample pushes the oldest out, so the mean tracks the newest samples.
// - The filter time is one of 2, 100, 1000 or 10000 ms, and 2 ms passes single samples through.
// - A 100 ms filter time averages the 50 most recent samples.
// - A 1000 ms filter time averages the 500 most recent samples.
// - A 10000 ms filter time averages the 5000 most recent samples.
// - After reset the filter time is 1000 ms.
// - Each channel picks its own range, 0 to 10 V or 4 to 20 mA.
// - After reset both channels use the voltage range.
// - Channel 0 result reads at index 800 and channel 1 at index 802.
`timescale 1ns/1ps
`default_nettype none
`include "aimavg_cfg.svh"
module analog_input_moving_average
   import aimavg_pkg::*;
#(
   parameter int unsigned SAMPLE_CYCLES = `SAMPLE_PERIOD_US * `CLK_MHZ
)(
   // System
   input wire logic CLK,
   input wire logic ARST_N,
   // Converter front end
   input wire logic [1:0][15:0] CONV_DATA,
   output logic [1:0] RANGE_CURRENT,
   output logic SAMPLE_TAKE,
   // AXI4-Lite write address
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [13:0] S_AXI_AWADDR,
   input wire logic [2:0] S_AXI_AWPROT,
   // AXI4-Lite write data
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   // AXI4-Lite write response
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   output logic [1:0] S_AXI_BRESP,
   // AXI4-Lite read
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   input wire logic [13:0] S_AXI_ARADDR,
   input wire logic [2:0] S_AXI_ARPROT,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP
);
   ////////////////////////////////////////////////////////////////////////////
   // Sampling tick

   logic [31:0] tick_cnt;
   logic tick;

   assign tick = (tick_cnt == SAMPLE_CYCLES - 1);

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tick_cnt <= 32'h0;
         SAMPLE_TAKE <= 1'b0;
      end else begin
         tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
         SAMPLE_TAKE <= tick;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration and window length

   cfg_t cfg;
   filt_t filt_prev;
   logic restart;
   logic [12:0] win_len;
   logic cfg_touched;

   // A filter change empties both windows so no stale samples mix in
   assign restart = (filt_prev != cfg.filt);

   always_comb begin
      case (cfg.filt)
         FILT_2MS: win_len = `WIN_2MS;
         FILT_100MS: win_len = `WIN_100MS;
         FILT_1000MS: win_len = `WIN_1000MS;
         FILT_10000MS: win_len = `WIN_10000MS;
         default: win_len = `WIN_1000MS;
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         filt_prev <= filt_t'(`CFG_FILT_RST);
      end else begin
         filt_prev <= cfg.filt;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         RANGE_CURRENT <= `CFG_RANGE_RST;
      end else begin
         RANGE_CURRENT <= cfg.range_current;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel window and divider

   logic [1:0][15:0] result;
   logic [1:0] full;
   logic [1:0][31:0] ch_sum;
   logic [1:0][12:0] ch_count;

   generate
      for (genvar c = 0; c < 2; c++) begin : g_ch
         logic upd;
         logic done;
         logic [15:0] quot;

         avg_window u_win (
            .clk(CLK),
            .arst_n(ARST_N),
            .restart(restart),
            .win_len(win_len),
            .sample_en(tick),
            .sample(CONV_DATA[c]),
            .sum(ch_sum[c]),
            .count(ch_count[c]),
            .upd(upd)
         );

         mean_divider u_div (
            .clk(CLK),
            .arst_n(ARST_N),
            .start(upd),
            .dividend(ch_sum[c]),
            .divisor(ch_count[c]),
            .done(done),
            .quotient(quot)
         );

         always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
               result[c] <= 16'h0;
            end else if (done) begin
               result[c] <= quot;
            end
         end

         assign full[c] = (ch_count[c] == win_len);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path

   logic aw_held;
   logic w_held;
   logic [11:0] aw_idx;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic aw_take;
   logic w_take;
   logic wr_go;

   assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_take = S_AXI_WVALID && S_AXI_WREADY;
   assign wr_go = aw_held && w_held && !S_AXI_BVALID;

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_idx <= 12'h0;
         wdata <= 32'h0;
         wstrb <= 4'h0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
      end else begin
         S_AXI_AWREADY <= !aw_held && !aw_take;
         S_AXI_WREADY <= !w_held && !w_take;
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_idx <= S_AXI_AWADDR[13:2];
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
         if (w_take) begin
            w_held <= 1'b1;
            wdata <= S_AXI_WDATA;
            wstrb <= S_AXI_WSTRB;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cfg.filt <= filt_t'(`CFG_FILT_RST);
         cfg.range_current <= `CFG_RANGE_RST;
         cfg_touched <= 1'b0;
      end else if (wr_go && aw_idx == `REG_CFG_IDX) begin
         cfg_touched <= 1'b1;
         if (wstrb[0]) begin
            cfg.filt <= filt_t'(wdata[`CFG_FILT_LSB +: 2]);
         end
         if (wstrb[1]) begin
            cfg.range_current <= wdata[`CFG_RANGE_LSB +: 2];
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `RESP_OKAY;
      end else if (wr_go) begin
         S_AXI_BVALID <= 1'b1;
         // Values and status are read-only; writes to them are dropped quietly
         case (aw_idx)
            `REG_CH0_IDX, `REG_CH1_IDX, `REG_CFG_IDX, `REG_STAT_IDX: S_AXI_BRESP <= `RESP_OKAY;
            default: S_AXI_BRESP <= `RESP_SLVERR;
         endcase
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path

   logic [31:0] next_rdata;
   logic [1:0] next_rresp;

   always_comb begin
      next_rdata = 32'h0;
      next_rresp = `RESP_OKAY;
      case (S_AXI_ARADDR[13:2])
         `REG_CH0_IDX: next_rdata = {16'h0, result[0]};
         `REG_CH1_IDX: next_rdata = {16'h0, result[1]};
         `REG_CFG_IDX: next_rdata = {22'h0, cfg.range_current, 6'h0, cfg.filt};
         `REG_STAT_IDX: next_rdata = {30'h0, full};
         default: next_rresp = `RESP_SLVERR;
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= `RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= next_rdata;
            S_AXI_RRESP <= next_rresp;
         end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_tick_period: assert property (@(posedge CLK) disable iff (!ARST_N)
      tick |=> tick_cnt == 32'h0 && !tick)
      else $error("sampling tick period broken");
   a_pass_through: assert property (@(posedge CLK) disable iff (!ARST_N)
      cfg.filt == FILT_2MS && !restart && tick |=> ##34 result[0] == $past(CONV_DATA[0], 35))
      else $error("2 ms setting did not pass the sample");
   a_win_small: assert property (@(posedge CLK) disable iff (!ARST_N)
      cfg.filt == FILT_100MS |-> win_len == 13'h0032)
      else $error("100 ms window not 50");
   a_win_medium: assert property (@(posedge CLK) disable iff (!ARST_N)
      cfg.filt == FILT_1000MS |-> win_len == 13'h01f4)
      else $error("1000 ms window not 500");
   a_win_large: assert property (@(posedge CLK) disable iff (!ARST_N)
      cfg.filt == FILT_10000MS |-> win_len == 13'h1388)
      else $error("10000 ms window not 5000");
   a_cfg_default: assert property (@(posedge CLK) disable iff (!ARST_N)
      !cfg_touched |-> cfg.filt == FILT_1000MS && RANGE_CURRENT == 2'h0)
      else $error("configuration left its reset value");
   a_range_follow: assert property (@(posedge CLK) disable iff (!ARST_N)
      $changed(cfg.range_current) |=> RANGE_CURRENT == $past(cfg.range_current))
      else $error("range output did not follow");
   a_restart_empty: assert property (@(posedge CLK) disable iff (!ARST_N)
      restart |=> ch_count[0] == 13'h0 && ch_count[1] == 13'h0)
      else $error("filter change did not empty windows");

   c_window_full: cover property (@(posedge CLK) disable iff (!ARST_N) full[0] && cfg.filt == FILT_100MS);
   c_filter_change: cover property (@(posedge CLK) disable iff (!ARST_N) restart);
   c_value_read: cover property (@(posedge CLK) disable iff (!ARST_N)
      S_AXI_RVALID && S_AXI_RREADY && S_AXI_RDATA[15:0] != 16'h0);
endmodule : analog_input_moving_average
`default_nettype wire

// >>> tb/conv_frontend.sv
/*
 Behavioural converter front end for the two analog channels.
 Assumes the bench sets the terminal levels and reads range from the block.
*/
`timescale 1ns/1ps
`default_nettype none
module conv_frontend (
   // Terminal levels
   input wire logic [1:0][15:0] level,
   // Range from the block
   input wire logic [1:0] range_current,
   // Converted values
   output logic [1:0][15:0] conv_data
);
   // Current range marks bit 15 so a lost range select shows in the mean
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         conv_data[c] = range_current[c] ? (level[c] | 16'h8000) : level[c];
      end
   end
endmodule : conv_frontend
`default_nettype wire

// >>> tb/analog_input_moving_average_tb.sv
/*
 Self-checking bench for the analog moving-average block over AXI4-Lite.
 Assumes a shortened sample period so that the 1000 ms window fits the run.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aimavg_cfg.svh"
module analog_input_moving_average_tb
   import aimavg_pkg::*;
;
   localparam int unsigned SC = 60;
   logic clk = 1'b0;
   logic arst_n;
   logic [1:0][15:0] level;
   logic [1:0][15:0] conv;
   logic [1:0] rng_out;
   logic take;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [13:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [1:0] rng;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   int last_take = 0;
   int k = 0;
   int w;
   int hist0[$];
   int hist1[$];

   always #5 clk = ~clk;

   analog_input_moving_average #(.SAMPLE_CYCLES(SC)) i_analog_input_moving_average (
      .CLK(clk), .ARST_N(arst_n), .CONV_DATA(conv), .RANGE_CURRENT(rng_out), .SAMPLE_TAKE(take),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp)
   );

   conv_frontend i_conv_frontend (.level(level), .range_current(rng_out), .conv_data(conv));

   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (n_fail == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish

   // About 660 sample periods are run; the ceiling leaves half again
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic cmp_val(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : cmp_val

   task automatic cmp_two(input string n, input logic [1:0] e, input logic [1:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : cmp_two

   function automatic logic [13:0] ba(input logic [11:0] i);
      return {i, 2'b00};
   endfunction : ba

   ////////////////////////////////////////////////////////////////////////////
   task automatic axi_write(input logic [13:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask : axi_write

   task automatic axi_read(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask : axi_read

   ////////////////////////////////////////////////////////////////////////////
   // Reference window: history capped at the selected length
   task automatic push(ref int q[$], input logic [15:0] v, input logic c);
      q.push_back(c ? (v | 16'h8000) : v);
      if (q.size() > w) q.pop_front();
   endtask : push

   function automatic int mean(input int q[$]);
      int s;
      s = 0;
      foreach (q[i]) s += q[i];
      return s / q.size();
   endfunction : mean

   // One sample period: record what was sampled, move the levels, read both means
   task automatic step();
      logic [31:0] d;
      logic [1:0] r;
      do @(posedge clk); while (take !== 1'b1);
      if (k > 0) cmp_val("period", SC, cyc - last_take);
      last_take = cyc;
      push(hist0, level[0], rng[0]);
      push(hist1, level[1], rng[1]);
      k++;
      level <= {16'(2000 + (k % 7) * 10), 16'((k * 37) % 1024)};
      repeat (38) @(posedge clk);
      axi_read(ba(`REG_CH0_IDX), d, r);
      cmp_val("ch0 mean", mean(hist0), d);
      axi_read(ba(`REG_CH1_IDX), d, r);
      cmp_val("ch1 mean", mean(hist1), d);
   endtask : step

   // Filter change empties the reference windows as the block does
   task automatic set_cfg(input logic [31:0] d, input int nw, input bit clr);
      logic [1:0] r;
      axi_write(ba(`REG_CFG_IDX), d, r);
      cmp_two("cfg resp", `RESP_OKAY, r);
      rng = d[9:8];
      w = nw;
      if (clr) begin
         hist0.delete();
         hist1.delete();
      end
   endtask : set_cfg

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      arst_n = 1'b0;
      level = {16'h07d0, 16'h0000};
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = 14'h0000;
      araddr = 14'h0000;
      wdata = 32'h0;
      rng = 2'h0;
      w = `WIN_1000MS;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      cmp_two("range after reset", 2'h0, rng_out);
      axi_read(ba(`REG_CFG_IDX), d, r);
      cmp_val("cfg after reset", 32'h2, d);
      axi_read(14'h0000, d, r);
      cmp_two("unmapped resp", `RESP_SLVERR, r);
      cmp_val("unmapped data", 32'h0, d);
      axi_write(ba(`REG_CH0_IDX), 32'hffff, r);
      cmp_two("ro write resp", `RESP_OKAY, r);
      // Default window overflows so the oldest samples must leave
      repeat (520) step();
      axi_read(ba(`REG_STAT_IDX), d, r);
      cmp_val("stat full", 32'h3, d);
      set_cfg(32'h0, `WIN_2MS, 1'b1);
      repeat (3) step();
      set_cfg(32'h200, `WIN_2MS, 1'b0);
      // Range pin is registered one edge after the write answer
      @(posedge clk);
      cmp_two("range out", 2'h2, rng_out);
      repeat (3) step();
      set_cfg(32'h1, `WIN_100MS, 1'b1);
      repeat (70) step();
      // Longest window only partly fills within the run
      set_cfg(32'h3, `WIN_10000MS, 1'b1);
      repeat (60) step();
      axi_read(ba(`REG_STAT_IDX), d, r);
      cmp_val("stat filling", 32'h0, d);
      axi_read(ba(`REG_CFG_IDX), d, r);
      cmp_val("cfg readback", 32'h3, d);
      tally_and_finish();
   end
endmodule : analog_input_moving_average_tb
`default_nettype wire
